// file: hdl/ipc_ctx_save.sv
/*
  interrupt entry context capture: return pc push and fast return stack.
  assumes the core pulses irq_entry_i for one cycle per vectoring.
*/
`timescale 1ns/10ps
`default_nettype none
module ipc_ctx_save (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 irq_entry_i,
  input  wire logic [20:0]          ret_pc_i,
  input  wire ipc_pkg::ipc_ctx_type ctx_i,
  output logic                      stack_push_o,
  output logic [20:0]               stack_pc_o,
  output ipc_pkg::ipc_ctx_type      fast_ctx_o
);
  // ==================================================
  // push strobe and pc for the hardware return stack
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stack_push_o <= 1'b0;
      stack_pc_o   <= 21'h000000;
    end else begin
      stack_push_o <= irq_entry_i;
      if (irq_entry_i) begin
        stack_pc_o <= ret_pc_i;
      end
    end
  end

  // ==================================================
  // single-level fast stack: a nested entry overwrites it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fast_ctx_o <= '0;
    end else if (irq_entry_i) begin
      fast_ctx_o <= ctx_i;
    end
  end
endmodule // ipc_ctx_save
`default_nettype wire

// file: hdl/ipc_edge_det.sv
/*
  edge detector for one external interrupt pin with selectable polarity.
  assumes the pin is synchronous to sys_clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module ipc_edge_det (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  input  wire logic rise_sel_i,
  output logic      edge_o
);
  logic prev_r;
  logic valid_r;

  // ==================================================
  // previous level; valid blocks a false edge right after reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prev_r  <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      prev_r  <= pin_i;
      valid_r <= 1'b1;
    end
  end

  // rising when select is one, falling when zero
  assign edge_o = valid_r & (rise_sel_i ? (pin_i & ~prev_r) : (~pin_i & prev_r));
endmodule // ipc_edge_det
`default_nettype wire

// file: hdl/ipc_pkg.sv
/*
  constants, field positions and carrier types of the interrupt priority block.
  assumes a 32-bit classic wishbone register bus with 8-bit registers in the low lane.
*/
// Function
// - one priority bit per peripheral source
// - priority bits act only with scheme enabled
// - first priority register: eight bits, reset high
// - second priority register, bit five reads zero
// - enhanced capture bit only on wide package
// - external pins edge-triggered, selectable edge
// - valid edge sets flag, enable gates it
// - enabled external pin wakes sleeping core
// - after wake, vector if global enable
// - pin one/two priority in third control
// - pin zero always high priority
// - timer zero 8-bit wrap sets flag
// - timer zero 16-bit: only full wrap
// - timer enable main bit5, priority second bit2
// - port b high nibble change sets flag
// - port b priority from second bit0
// - entry pushes pc, saves context fast
package ipc_pkg;
  // ==================================================
  // register byte addresses
  localparam logic [7:0] ADR_PRIO_ONE = 8'h00;
  localparam logic [7:0] ADR_PRIO_TWO = 8'h04;
  localparam logic [7:0] ADR_CTL_MAIN = 8'h08;
  localparam logic [7:0] ADR_CTL_SEC  = 8'h0c;
  localparam logic [7:0] ADR_CTL_THR  = 8'h10;
  localparam logic [7:0] ADR_SCHEME   = 8'h14;
  localparam logic [7:0] ADR_STATE    = 8'h18;
  // ==================================================
  // reset values and writable masks
  localparam logic [7:0] RST_PRIO_ONE = 8'hff;
  localparam logic [7:0] RST_PRIO_TWO = 8'hdf;
  localparam logic [7:0] MSK_PRIO_TWO = 8'hdf;
  localparam logic [7:0] MSK_PRIO_NAR = 8'hde;
  localparam logic [7:0] RST_CTL_MAIN = 8'h00;
  localparam logic [7:0] RST_CTL_SEC  = 8'h75;
  localparam logic [7:0] MSK_CTL_SEC  = 8'h75;
  localparam logic [7:0] RST_CTL_THR  = 8'hc0;
  localparam logic [7:0] MSK_CTL_THR  = 8'hdb;
  // ==================================================
  // field positions
  localparam int MAIN_GLB  = 7;
  localparam int MAIN_PEIE = 6;
  localparam int MAIN_T0E  = 5;
  localparam int MAIN_XP0E = 4;
  localparam int MAIN_RBE  = 3;
  localparam int MAIN_T0F  = 2;
  localparam int MAIN_XP0F = 1;
  localparam int MAIN_RBF  = 0;
  localparam int SEC_EDGE0 = 6;
  localparam int SEC_EDGE1 = 5;
  localparam int SEC_EDGE2 = 4;
  localparam int SEC_T0P   = 2;
  localparam int SEC_RBP   = 0;
  localparam int THR_XP2P  = 7;
  localparam int THR_XP1P  = 6;
  localparam int THR_XP2E  = 4;
  localparam int THR_XP1E  = 3;
  localparam int THR_XP2F  = 1;
  localparam int THR_XP1F  = 0;
  localparam int SCH_EN    = 0;
  // ==================================================
  // timer wrap values
  localparam logic [7:0]  T0_TOP8  = 8'hff;
  localparam logic [15:0] T0_TOP16 = 16'hffff;
  // ==================================================
  // context saved on interrupt entry
  typedef struct packed {
    logic [7:0] working_register;
    logic [7:0] status;
    logic [7:0] bank_select_register;
  } ipc_ctx_type;
endpackage

// file: hdl/ipc_top.sv
/*
  interrupt priority, external pin, timer zero, port b change and context logic.
  assumes a classic wishbone master, peripheral requests already flag-and-enable
  gated, and a core that acknowledges vectoring with a one-cycle entry pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module ipc_top #(
  parameter bit WIDE_PKG = 1'b1
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic [15:0]          periph_req_i,
  input  wire logic [2:0]           ext_pin_i,
  input  wire logic [15:0]          timer_zero_count_i,
  input  wire logic                 timer_zero_wide_i,
  input  wire logic [3:0]           port_b_high_i,
  input  wire logic                 sleep_i,
  input  wire logic                 irq_entry_i,
  input  wire logic [20:0]          ret_pc_i,
  input  wire ipc_pkg::ipc_ctx_type ctx_i,
  output logic                      irq_high_o,
  output logic                      irq_low_o,
  output logic                      wake_o,
  output logic                      wake_branch_o,
  output logic                      stack_push_o,
  output logic [20:0]               stack_pc_o,
  output ipc_pkg::ipc_ctx_type      fast_ctx_o
);
  logic [7:0]  prio_one_r;
  logic [7:0]  prio_two_r;
  logic [7:0]  ctl_main_r;
  logic [7:0]  ctl_sec_r;
  logic [7:0]  ctl_thr_r;
  logic        scheme_r;
  logic        ack_r;
  logic [7:0]  rd_nxt;
  logic        wr_en;
  logic [2:0]  ext_edge;
  logic [2:0]  edge_sel;
  logic [15:0] t0_prev_r;
  logic        t0_wrap;
  logic [3:0]  rb_prev_r;
  logic        rb_valid_r;
  logic        rb_change;
  logic        sleep_prev_r;
  logic [2:0]  wake_en_r;
  logic [2:0]  ext_flag;
  logic [2:0]  ext_en;
  logic [4:0]  core_req;
  logic [4:0]  core_prio;
  logic [15:0] per_req;
  logic [15:0] per_prio;
  logic        hi_any;
  logic        lo_any;
  logic [7:0]  prio_two_msk;

  // 28-pin parts lose the enhanced capture bit
  assign prio_two_msk = WIDE_PKG ? ipc_pkg::MSK_PRIO_TWO : ipc_pkg::MSK_PRIO_NAR;

  // ==================================================
  // wishbone slave: ack one cycle after request, write lands on the ack edge
  assign wr_en    = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0];
  assign wb_ack_o = ack_r;

  // ack drops the cycle after it was given
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
    end
  end

  // read mux; unmapped addresses read zero but still ack
  always_comb begin
    rd_nxt = 8'h00;
    unique case (wb_adr_i)
      ipc_pkg::ADR_PRIO_ONE: rd_nxt = prio_one_r;
      ipc_pkg::ADR_PRIO_TWO: rd_nxt = prio_two_r & prio_two_msk;
      ipc_pkg::ADR_CTL_MAIN: rd_nxt = ctl_main_r;
      ipc_pkg::ADR_CTL_SEC:  rd_nxt = ctl_sec_r;
      ipc_pkg::ADR_CTL_THR:  rd_nxt = ctl_thr_r;
      ipc_pkg::ADR_SCHEME:   rd_nxt = {7'h00, scheme_r};
      ipc_pkg::ADR_STATE:    rd_nxt = {4'h0, wake_o, sleep_prev_r, irq_low_o, irq_high_o};
      default:               rd_nxt = 8'h00;
    endcase
  end

  // read data captured on the request edge, held through the ack
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_cyc_i & wb_stb_i & ~ack_r) begin
      wb_dat_o <= {24'h000000, rd_nxt};
    end
  end

  // ==================================================
  // priority registers, high after reset except bit 5 of the second
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prio_one_r <= ipc_pkg::RST_PRIO_ONE;
      prio_two_r <= ipc_pkg::RST_PRIO_TWO;
      scheme_r   <= 1'b0;
    end else if (wr_en) begin
      if (wb_adr_i == ipc_pkg::ADR_PRIO_ONE) begin
        prio_one_r <= wb_dat_i[7:0];
      end
      if (wb_adr_i == ipc_pkg::ADR_PRIO_TWO) begin
        prio_two_r <= wb_dat_i[7:0] & ipc_pkg::MSK_PRIO_TWO;
      end
      if (wb_adr_i == ipc_pkg::ADR_SCHEME) begin
        scheme_r <= wb_dat_i[ipc_pkg::SCH_EN];
      end
    end
  end

  // ==================================================
  // source detection
  assign edge_sel = {ctl_sec_r[ipc_pkg::SEC_EDGE2], ctl_sec_r[ipc_pkg::SEC_EDGE1],
                     ctl_sec_r[ipc_pkg::SEC_EDGE0]};

  // one detector per external pin
  for (genvar g = 0; g < 3; g++) begin : g_ext
    ipc_edge_det u_edge (
      .sys_clk_i  (sys_clk_i),
      .rst_i      (rst_i),
      .pin_i      (ext_pin_i[g]),
      .rise_sel_i (edge_sel[g]),
      .edge_o     (ext_edge[g])
    );
  end

  // timer wrap: 8-bit mode watches the low byte, 16-bit the pair
  assign t0_wrap = timer_zero_wide_i
                 ? (t0_prev_r == ipc_pkg::T0_TOP16) && (timer_zero_count_i == 16'h0000)
                 : (t0_prev_r[7:0] == ipc_pkg::T0_TOP8) && (timer_zero_count_i[7:0] == 8'h00);

  // any difference on the high nibble is a change
  assign rb_change = rb_valid_r & (rb_prev_r != port_b_high_i);

  // history of timer and port levels
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      t0_prev_r  <= 16'h0000;
      rb_prev_r  <= 4'h0;
      rb_valid_r <= 1'b0;
    end else begin
      t0_prev_r  <= timer_zero_count_i;
      rb_prev_r  <= port_b_high_i;
      rb_valid_r <= 1'b1;
    end
  end

  // ==================================================
  // main control: hardware set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctl_main_r <= ipc_pkg::RST_CTL_MAIN;
    end else begin
      if (wr_en && wb_adr_i == ipc_pkg::ADR_CTL_MAIN) begin
        ctl_main_r <= wb_dat_i[7:0];
      end
      if (t0_wrap) begin
        ctl_main_r[ipc_pkg::MAIN_T0F] <= 1'b1;
      end
      if (ext_edge[0]) begin
        ctl_main_r[ipc_pkg::MAIN_XP0F] <= 1'b1;
      end
      if (rb_change) begin
        ctl_main_r[ipc_pkg::MAIN_RBF] <= 1'b1;
      end
    end
  end

  // edge selects and priorities of timer and port b
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctl_sec_r <= ipc_pkg::RST_CTL_SEC;
    end else if (wr_en && wb_adr_i == ipc_pkg::ADR_CTL_SEC) begin
      ctl_sec_r <= wb_dat_i[7:0] & ipc_pkg::MSK_CTL_SEC;
    end
  end

  // pins one and two: flags set by edge, set wins over clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctl_thr_r <= ipc_pkg::RST_CTL_THR;
    end else begin
      if (wr_en && wb_adr_i == ipc_pkg::ADR_CTL_THR) begin
        ctl_thr_r <= wb_dat_i[7:0] & ipc_pkg::MSK_CTL_THR;
      end
      if (ext_edge[1]) begin
        ctl_thr_r[ipc_pkg::THR_XP1F] <= 1'b1;
      end
      if (ext_edge[2]) begin
        ctl_thr_r[ipc_pkg::THR_XP2F] <= 1'b1;
      end
    end
  end

  // ==================================================
  // request routing
  assign ext_flag = {ctl_thr_r[ipc_pkg::THR_XP2F], ctl_thr_r[ipc_pkg::THR_XP1F],
                     ctl_main_r[ipc_pkg::MAIN_XP0F]};
  assign ext_en   = {ctl_thr_r[ipc_pkg::THR_XP2E], ctl_thr_r[ipc_pkg::THR_XP1E],
                     ctl_main_r[ipc_pkg::MAIN_XP0E]};

  // a flag without its enable never reaches the core
  assign core_req = {ctl_main_r[ipc_pkg::MAIN_RBF] & ctl_main_r[ipc_pkg::MAIN_RBE],
                     ctl_main_r[ipc_pkg::MAIN_T0F] & ctl_main_r[ipc_pkg::MAIN_T0E],
                     ext_flag & ext_en};

  // pin zero has no priority bit and is hard-wired high
  assign core_prio = {ctl_sec_r[ipc_pkg::SEC_RBP], ctl_sec_r[ipc_pkg::SEC_T0P],
                      ctl_thr_r[ipc_pkg::THR_XP2P], ctl_thr_r[ipc_pkg::THR_XP1P],
                      1'b1};

  assign per_req  = periph_req_i & {prio_two_msk, 8'hff};
  assign per_prio = {prio_two_r, prio_one_r};

  // with the scheme off every priority bit is ignored
  assign hi_any = |(core_req & (core_prio | {5{~scheme_r}}))
                | |(per_req & (per_prio | {16{~scheme_r}}));
  assign lo_any = scheme_r & (|(core_req & ~core_prio) | |(per_req & ~per_prio));

  // legacy mode: bit 7 global, bit 6 peripherals; scheme mode: bit 7 high, bit 6 low
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_high_o <= 1'b0;
      irq_low_o  <= 1'b0;
    end else if (scheme_r) begin
      irq_high_o <= ctl_main_r[ipc_pkg::MAIN_GLB] & hi_any;
      irq_low_o  <= ctl_main_r[ipc_pkg::MAIN_PEIE] & lo_any;
    end else begin
      irq_high_o <= ctl_main_r[ipc_pkg::MAIN_GLB]
                  & (|core_req | (ctl_main_r[ipc_pkg::MAIN_PEIE] & |per_req));
      irq_low_o  <= 1'b0;
    end
  end

  // ==================================================
  // wake-up: enables snapshot on sleep entry decide who may wake
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sleep_prev_r  <= 1'b0;
      wake_en_r     <= 3'h0;
      wake_o        <= 1'b0;
      wake_branch_o <= 1'b0;
    end else begin
      sleep_prev_r <= sleep_i;
      if (sleep_i & ~sleep_prev_r) begin
        wake_en_r <= ext_en;
      end
      wake_o        <= sleep_prev_r & |(ext_flag & wake_en_r);
      wake_branch_o <= sleep_prev_r & |(ext_flag & wake_en_r)
                     & ctl_main_r[ipc_pkg::MAIN_GLB];
    end
  end

  // ==================================================
  // context capture on entry
  ipc_ctx_save u_ctx (
    .sys_clk_i    (sys_clk_i),
    .rst_i        (rst_i),
    .irq_entry_i  (irq_entry_i),
    .ret_pc_i     (ret_pc_i),
    .ctx_i        (ctx_i),
    .stack_push_o (stack_push_o),
    .stack_pc_o   (stack_pc_o),
    .fast_ctx_o   (fast_ctx_o)
  );

  // ==================================================
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_prio_one_wr;
    wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & (wb_adr_i == ipc_pkg::ADR_PRIO_ONE) & ~ack_r
    ##1 ack_r;
  endsequence

  sequence s_xp0_pending;
    ext_edge[0] & ctl_main_r[ipc_pkg::MAIN_XP0E] & scheme_r & ctl_main_r[ipc_pkg::MAIN_GLB]
    ##1 ctl_main_r[ipc_pkg::MAIN_XP0E] & scheme_r & ctl_main_r[ipc_pkg::MAIN_GLB];
  endsequence

  chk_prio_one_write: assert property (s_prio_one_wr |=> prio_one_r == $past(wb_dat_i[7:0]))
    else $error("priority one write lost");
  chk_prio_two_gap: assert property (ack_r & (wb_adr_i == ipc_pkg::ADR_PRIO_TWO) |-> !wb_dat_o[5])
    else $error("priority two bit 5 not zero");
  chk_legacy_no_low: assert property (!scheme_r |=> !irq_low_o)
    else $error("low request while scheme off");
  chk_xp0_to_high: assert property (s_xp0_pending |=> irq_high_o)
    else $error("pin zero not routed high");
  chk_t0_byte_wrap: assert property (!timer_zero_wide_i && t0_prev_r[7:0] == 8'hff
    && timer_zero_count_i[7:0] == 8'h00 |=> ctl_main_r[ipc_pkg::MAIN_T0F])
    else $error("timer byte wrap missed");
  chk_t0_wide_only: assert property (timer_zero_wide_i && t0_prev_r[15:8] != 8'hff
    && !ctl_main_r[ipc_pkg::MAIN_T0F] && !wr_en |=> !ctl_main_r[ipc_pkg::MAIN_T0F])
    else $error("timer flag set without full wrap");
  chk_rb_change_flag: assert property ($changed(port_b_high_i) && rb_valid_r
    |=> ctl_main_r[ipc_pkg::MAIN_RBF])
    else $error("port change not flagged");
  chk_edge_flag_set: assert property (ext_edge[1] |=> ctl_thr_r[ipc_pkg::THR_XP1F])
    else $error("pin one edge lost");
  chk_no_req_disabled: assert property (core_req == 5'h00 && per_req == 16'h0000
    |=> !irq_high_o && !irq_low_o)
    else $error("request without flag and enable");
  chk_wake_branch: assert property (wake_branch_o |-> wake_o && $past(ctl_main_r[ipc_pkg::MAIN_GLB]))
    else $error("branch without wake or global enable");
  chk_ctx_push: assert property (irq_entry_i |=> stack_push_o && stack_pc_o == $past(ret_pc_i)
    && fast_ctx_o == $past(ctx_i))
    else $error("entry context not saved");

  // ==================================================
  // priority routing of the core sources with the scheme on
  // a pin two edge marked low must surface on the low request, never be lost to the high one
  sequence s_xp2_low;
    ext_edge[2] & ctl_thr_r[ipc_pkg::THR_XP2E] & ~ctl_thr_r[ipc_pkg::THR_XP2P]
    & scheme_r & ctl_main_r[ipc_pkg::MAIN_PEIE]
    ##1 ctl_thr_r[ipc_pkg::THR_XP2E] & ~ctl_thr_r[ipc_pkg::THR_XP2P]
    & scheme_r & ctl_main_r[ipc_pkg::MAIN_PEIE];
  endsequence

  chk_xp2_low_route: assert property (s_xp2_low |=> irq_low_o)
    else $error("pin two low priority not routed low");
  // timer zero with its priority bit set goes out on the high request
  chk_t0_prio_high: assert property (ctl_main_r[ipc_pkg::MAIN_T0F] && ctl_main_r[ipc_pkg::MAIN_T0E]
    && ctl_sec_r[ipc_pkg::SEC_T0P] && scheme_r && ctl_main_r[ipc_pkg::MAIN_GLB] |=> irq_high_o)
    else $error("timer high priority not routed high");
  // port b change with its priority bit clear goes out on the low request
  chk_rb_prio_low: assert property (ctl_main_r[ipc_pkg::MAIN_RBF] && ctl_main_r[ipc_pkg::MAIN_RBE]
    && !ctl_sec_r[ipc_pkg::SEC_RBP] && scheme_r && ctl_main_r[ipc_pkg::MAIN_PEIE] |=> irq_low_o)
    else $error("port change low priority not routed low");
  // an awake core is never told to wake
  chk_wake_needs_sleep: assert property (!sleep_prev_r |=> !wake_o)
    else $error("wake raised while not sleeping");
endmodule // ipc_top
`default_nettype wire

// file: tb/ipc_core_model.sv
/*
  core model: vectors on a pending request when the bench allows it,
  handing over a return pc and a context word. assumes one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module ipc_core_model (
  input  wire logic            sys_clk_i,
  input  wire logic            rst_i,
  input  wire logic            irq_i,
  input  wire logic            take_i,
  output logic                 entry_o,
  output logic [20:0]          pc_o,
  output ipc_pkg::ipc_ctx_type ctx_o
);
  logic [20:0] pc_r;
  logic        go;
  assign go = take_i && irq_i && !entry_o;
  // ==================================================
  // vectoring: never two pulses in a row, so each entry stands alone
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      entry_o <= 1'b0;
      pc_r    <= 21'h01000;
      pc_o    <= 21'h0;
      ctx_o   <= '0;
    end else begin
      entry_o <= go;
      if (go) begin
        pc_o  <= pc_r;
        ctx_o <= {pc_r[7:0], ~pc_r[7:0], 8'h0f};
        pc_r  <= pc_r + 21'h00101;
      end else begin
        pc_o  <= ~pc_o;  // stale data toggles so nothing matches by luck
        ctx_o <= ~ctx_o;
      end
    end
  end
endmodule // ipc_core_model
`default_nettype wire

// file: tb/ipc_top_test.sv
/*
  self-checking bench for the interrupt priority block.
  assumes the design's one-cycle flag-to-request latency and a one-cycle ack.
*/
`timescale 1ns/10ps
`default_nettype none
module ipc_top_test;
  logic                 sys_clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, t0_wide, sleep, take;
  logic [7:0]           wb_adr;
  logic [3:0]           wb_sel, pbh;
  logic [31:0]          wb_wdat, wb_rdat;
  logic [15:0]          preq, t0_cnt;
  logic [2:0]           pins;
  logic                 entry, ih, il, wake, wbr, push;
  logic [20:0]          pc, spc;
  ipc_pkg::ipc_ctx_type ctx, fctx;
  int                   miscompares, checks, cycles;

  ipc_top #(.WIDE_PKG(1'b1)) i_ipc_top (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .periph_req_i(preq), .ext_pin_i(pins), .timer_zero_count_i(t0_cnt), .timer_zero_wide_i(t0_wide),
    .port_b_high_i(pbh), .sleep_i(sleep), .irq_entry_i(entry), .ret_pc_i(pc), .ctx_i(ctx),
    .irq_high_o(ih), .irq_low_o(il), .wake_o(wake), .wake_branch_o(wbr), .stack_push_o(push),
    .stack_pc_o(spc), .fast_ctx_o(fctx));

  ipc_core_model i_ipc_core_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .irq_i(ih | il),
    .take_i(take), .entry_o(entry), .pc_o(pc), .ctx_o(ctx));

  // ==================================================
  // helpers: compare, bus cycle, idle
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // holds the request until ack is sampled, then one idle cycle; only the run timeout ends the wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= w;
    wb_sel  <= 4'h1;
    wb_adr  <= a;
    wb_wdat <= {24'h0, d};
    do begin
      @(posedge sys_clk_i);
    end while (wb_ack !== 1'b1);
    r = wb_rdat[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    bus(1'b0, a, 8'h0, r);
    chk(32'(r), 32'(exp));
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // ==================================================
  // scenarios
  task automatic test_regs;
    rdc(ipc_pkg::ADR_PRIO_ONE, 8'hff);
    rdc(ipc_pkg::ADR_PRIO_TWO, 8'hdf);
    rdc(ipc_pkg::ADR_CTL_MAIN, 8'h00);
    rdc(ipc_pkg::ADR_CTL_SEC, 8'h75);
    rdc(ipc_pkg::ADR_CTL_THR, 8'hc0);
    wr(ipc_pkg::ADR_PRIO_TWO, 8'hff);
    rdc(ipc_pkg::ADR_PRIO_TWO, 8'hdf);
    wr(ipc_pkg::ADR_PRIO_TWO, 8'h00);
    rdc(ipc_pkg::ADR_PRIO_TWO, 8'h00);
    wr(8'h1c, 8'hff);
    rdc(8'h1c, 8'h00);
    $display("test regs done");
  endtask

  task automatic test_periph;
    wr(ipc_pkg::ADR_SCHEME, 8'h01);
    wr(ipc_pkg::ADR_PRIO_ONE, 8'hfe);
    wr(ipc_pkg::ADR_CTL_MAIN, 8'hc0);
    preq <= 16'h0001;
    step(3);
    chk(32'({ih, il}), 32'h1);
    wr(ipc_pkg::ADR_SCHEME, 8'h00);
    step(3);
    chk(32'({ih, il}), 32'h2);
    preq <= 16'h8000;
    wr(ipc_pkg::ADR_SCHEME, 8'h01);
    wr(ipc_pkg::ADR_PRIO_TWO, 8'h5f);
    step(3);
    chk(32'({ih, il}), 32'h1);
    wr(ipc_pkg::ADR_CTL_MAIN, 8'h00);
    step(3);
    chk(32'({ih, il}), 32'h0);
    preq <= 16'h0000;
    $display("test periph done");
  endtask

  task automatic test_pins;
    wr(ipc_pkg::ADR_CTL_MAIN, 8'h90);
    pins <= 3'b001;
    step(3);
    chk(32'(ih), 32'h1);
    rdc(ipc_pkg::ADR_CTL_MAIN, 8'h92);
    wr(ipc_pkg::ADR_CTL_MAIN, 8'h90);
    pins <= 3'b000;
    step(3);
    rdc(ipc_pkg::ADR_CTL_MAIN, 8'h90);
    wr(ipc_pkg::ADR_CTL_SEC, 8'h35);
    pins <= 3'b001;
    step(3);
    rdc(ipc_pkg::ADR_CTL_MAIN, 8'h90);
    pins <= 3'b000;
    step(3);
    rdc(ipc_pkg::ADR_CTL_MAIN, 8'h92);
    wr(ipc_pkg::ADR_CTL_MAIN, 8'h82);
    step(3);
    chk(32'(ih), 32'h0);
    wr(ipc_pkg::ADR_CTL_MAIN, 8'hc0);
    wr(ipc_pkg::ADR_CTL_SEC, 8'h75);
    wr(ipc_pkg::ADR_CTL_THR, 8'h50);
    pins <= 3'b100;
    step(3);
    chk(32'({ih, il}), 32'h1);
    wr(ipc_pkg::ADR_CTL_THR, 8'hc0);
    pins <= 3'b000;
    $display("test pins done");
  endtask

  task automatic test_timer;
    wr(ipc_pkg::ADR_CTL_MAIN, 8'ha0);
    t0_cnt <= 16'h00ff;
    step(1);
    t0_cnt <= 16'h0000;
    step(3);
    rdc(ipc_pkg::ADR_CTL_MAIN, 8'ha4);
    wr(ipc_pkg::ADR_CTL_SEC, 8'h71);
    wr(ipc_pkg::ADR_CTL_MAIN, 8'he4);
    step(3);
    chk(32'({ih, il}), 32'h1);
    wr(ipc_pkg::ADR_CTL_MAIN, 8'h00);
    t0_wide <= 1'b1;
    t0_cnt  <= 16'h00ff;
    step(1);
    t0_cnt <= 16'h0100;
    step(3);
    rdc(ipc_pkg::ADR_CTL_MAIN, 8'h00);
    t0_cnt <= 16'hffff;
    step(1);
    t0_cnt <= 16'h0000;
    step(3);
    rdc(ipc_pkg::ADR_CTL_MAIN, 8'h04);
    wr(ipc_pkg::ADR_CTL_MAIN, 8'h00);
    $display("test timer done");
  endtask

  task automatic test_portb;
    wr(ipc_pkg::ADR_CTL_MAIN, 8'hc8);
    wr(ipc_pkg::ADR_CTL_SEC, 8'h74);
    pbh <= 4'h4;
    step(3);
    rdc(ipc_pkg::ADR_CTL_MAIN, 8'hc9);
    chk(32'({ih, il}), 32'h1);
    wr(ipc_pkg::ADR_CTL_MAIN, 8'h00);
    wr(ipc_pkg::ADR_CTL_SEC, 8'h75);
    wr(ipc_pkg::ADR_SCHEME, 8'h00);
    $display("test portb done");
  endtask

  task automatic test_wake;
    wr(ipc_pkg::ADR_CTL_THR, 8'hc8);
    sleep <= 1'b1;
    step(2);
    pins <= 3'b010;
    step(3);
    chk(32'({wake, wbr}), 32'h2);
    sleep <= 1'b0;
    pins  <= 3'b000;
    wr(ipc_pkg::ADR_CTL_THR, 8'hc8);
    wr(ipc_pkg::ADR_CTL_MAIN, 8'h80);
    sleep <= 1'b1;
    step(2);
    pins <= 3'b010;
    step(3);
    chk(32'({wake, wbr}), 32'h3);
    sleep <= 1'b0;
    pins  <= 3'b000;
    wr(ipc_pkg::ADR_CTL_THR, 8'hc0);
    wr(ipc_pkg::ADR_CTL_MAIN, 8'h00);
    $display("test wake done");
  endtask

  task automatic test_entry;
    logic [20:0]          epc;
    ipc_pkg::ipc_ctx_type ectx;
    int                   n;
    wr(ipc_pkg::ADR_CTL_MAIN, 8'ha4);
    take <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (entry !== 1'b1 && n < 10);
    epc  = pc;
    ectx = ctx;
    take <= 1'b0;
    step(1);
    chk(32'(push), 32'h1);
    chk(32'(spc), 32'(epc));
    chk(32'(fctx), 32'(ectx));
    step(1);
    chk(32'(push), 32'h0);
    wr(ipc_pkg::ADR_CTL_MAIN, 8'h00);
    $display("test entry done");
  endtask

  // ==================================================
  // closing report and hang guard
  task automatic wrap_up;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up;
    end
  end

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    {rst_i, wb_cyc, wb_stb, wb_we, t0_wide, sleep, take} <= 7'b1000000;
    {wb_adr, pbh, wb_wdat, preq, t0_cnt, pins} <= '0;
    wb_sel <= 4'h1;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    step(2);
    test_regs;
    test_periph;
    test_pins;
    test_timer;
    test_portb;
    test_wake;
    test_entry;
    wrap_up;
  end
endmodule // ipc_top_test
`default_nettype wire
